// ### design/cmoc_pkg.sv
// shared constants, enums and carriers of the clock multiplier output control
package cmoc_pkg;
  // system clock and timing figures
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned LOCK_TIME_NS  = 100000;  // pll settle time after reference appears
  localparam int unsigned LOCK_CYC      = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REF_LOSS_NS   = 200;     // longest gap between reference edges
  localparam int unsigned REF_LOSS_CYC  = REF_LOSS_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_LOCK_WAIT = 8'h04;
  localparam logic [7:0] ADDR_RATIO     = 8'h08;

  // status field positions
  localparam int unsigned STAT_REF_BIT  = 0;
  localparam int unsigned STAT_LOCK_BIT = 1;
  localparam int unsigned STAT_DRV_LSB  = 2;
  localparam int unsigned STAT_MODE_LSB = 4;
  localparam int unsigned STAT_TAP_LSB  = 8;

  // reset value and stop parking level
  localparam logic [15:0] LOCK_WAIT_RST = 16'(LOCK_CYC);
  localparam logic        STOP_LEVEL    = 1'h1;  // parked level of both outputs

  // multiply ratio in thirds
  localparam logic [7:0] RATIO_X3_4    = 8'h0c;
  localparam logic [7:0] RATIO_X3_6    = 8'h12;
  localparam logic [7:0] RATIO_X3_8    = 8'h18;
  localparam logic [7:0] RATIO_X3_16_3 = 8'h10;

  // output source modes
  typedef enum logic [1:0] {
    MODE_ALIGN  = 2'b00,
    MODE_BYPASS = 2'b01,
    MODE_TEST   = 2'b10,
    MODE_HIZ    = 2'b11
  } cmoc_mode_e;

  // output driver states
  typedef enum logic [1:0] {
    DRV_PDN  = 2'b00,
    DRV_STOP = 2'b01,
    DRV_RUN  = 2'b10
  } cmoc_drv_e;

  // lock acquisition states
  typedef enum logic [1:0] {
    LK_IDLE   = 2'b00,
    LK_ACQ    = 2'b01,
    LK_LOCKED = 2'b10
  } cmoc_lk_e;

  // differential output pin pair with enables
  typedef struct packed {
    logic clk;
    logic clk_oe;
    logic cmp;
    logic cmp_oe;
  } cmoc_pins_s;
endpackage

// ### design/cmoc_phase_align.sv
// bang-bang phase aligner: delay line on the pll clock steered by the phase detector
`timescale 1ns/1ns
`default_nettype none
module cmoc_phase_align
  import cmoc_pkg::*;
#(
  parameter int unsigned TAPS = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,       // aligner runs only while locked
  input  wire logic       pll_clk_i,
  input  wire logic       proc_ph_i,
  input  wire logic       chan_ph_i,
  output logic            aligned_o,
  output logic [7:0]      tap_o
);
  localparam int unsigned TW = $clog2(TAPS);
  localparam logic [TW-1:0] TAP_MAX = TW'(TAPS - 1);
  localparam logic [TW-1:0] TAP_MID = TW'(TAPS / 2);  // centre gives about half the taps each way

  // tap count must fit the status field
  if (TAPS < 2 || TAPS > 256) begin : g_bad_taps
    $error("TAPS must lie in 2..256");
  end

  logic [TAPS-1:0] line_r, line_nxt;      // sampled delay line
  logic [TW-1:0]   tap_r, tap_nxt;        // selected delay
  logic            proc_d_r, proc_d_nxt;  // previous processor phase level
  logic            al_r, al_nxt;          // aligned clock flop

  // next state: shift the line, step the tap on each processor rising edge while enabled, holding at either end
  always_comb begin
    line_nxt   = {line_r[TAPS-2:0], pll_clk_i};
    proc_d_nxt = proc_ph_i;
    al_nxt     = line_r[tap_r];
    tap_nxt    = tap_r;
    if (!en_i) begin
      tap_nxt = TAP_MID;  // recentre so capture range is symmetric
    end else if (proc_ph_i && !proc_d_r) begin
      if (chan_ph_i && tap_r != TAP_MAX) begin
        tap_nxt = tap_r + 1'b1;  // channel leads: add delay
      end else if (!chan_ph_i && tap_r != '0) begin
        tap_nxt = tap_r - 1'b1;  // channel lags: remove delay
      end
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_r   <= '0;
      tap_r    <= TAP_MID;
      proc_d_r <= 1'b0;
      al_r     <= 1'b0;
    end else begin
      line_r   <= line_nxt;
      tap_r    <= tap_nxt;
      proc_d_r <= proc_d_nxt;
      al_r     <= al_nxt;
    end
  end

  assign aligned_o = al_r;
  assign tap_o     = 8'(tap_r);

  a_phase_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_i && proc_ph_i && !proc_d_r && chan_ph_i && tap_r != TAP_MAX) |=> tap_r == $past(tap_r) + 1'b1)
    else $error("aligner did not add delay when channel led");
endmodule // cmoc_phase_align
`default_nettype wire

// ### design/cmoc_out_drv.sv
// output driver: power state, stop parking and source selection for the pin pair
`timescale 1ns/1ns
`default_nettype none
module cmoc_out_drv
  import cmoc_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  power_down_n_i,
  input  wire logic  output_stop_n_i,
  input  wire logic  mode_select_0_i,
  input  wire logic  mode_select_1_i,
  input  wire logic  mode_select_2_i,
  input  wire logic  locked_i,
  input  wire logic  aligned_i,
  input  wire logic  pll_i,
  input  wire logic  ref_i,
  output cmoc_pins_s pins_o,
  output cmoc_drv_e  drv_o,
  output cmoc_mode_e mode_o
);
  cmoc_pins_s pins_r, pins_nxt;  // registered pin pair
  cmoc_mode_e mode;               // decoded source mode
  cmoc_drv_e  drv;                // decoded driver state
  logic       src;                // chosen true-phase source

  // decode pins, select source, build next pin values
  always_comb begin
    case ({mode_select_0_i, mode_select_1_i, mode_select_2_i})
      3'b000:  mode = MODE_ALIGN;
      3'b100:  mode = MODE_BYPASS;
      3'b110:  mode = MODE_TEST;
      default: mode = MODE_HIZ;     // 01x, 111 and reserved codes float
    endcase
    if (!power_down_n_i) begin
      drv = DRV_PDN;                // stop input ignored
    end else if (!output_stop_n_i) begin
      drv = DRV_STOP;
    end else begin
      drv = DRV_RUN;
    end
    // pll sources are undefined until lock, so they are held low
    case (mode)
      MODE_ALIGN:  src = locked_i & aligned_i;
      MODE_BYPASS: src = locked_i & pll_i;
      MODE_TEST:   src = ref_i;                 // pll bypassed
      default:     src = 1'b0;
    endcase
    case (drv)
      DRV_PDN:  pins_nxt = '{clk: 1'b0, clk_oe: 1'b1, cmp: 1'b0, cmp_oe: 1'b1};
      DRV_STOP: pins_nxt = '{clk: STOP_LEVEL, clk_oe: 1'b1, cmp: STOP_LEVEL, cmp_oe: 1'b1};
      default: begin
        if (mode == MODE_HIZ) begin
          pins_nxt = '{clk: 1'b0, clk_oe: 1'b0, cmp: 1'b0, cmp_oe: 1'b0};
        end else if (mode == MODE_TEST || locked_i) begin
          pins_nxt = '{clk: src, clk_oe: 1'b1, cmp: ~src, cmp_oe: 1'b1};
        end else begin
          pins_nxt = '{clk: 1'b0, clk_oe: 1'b1, cmp: 1'b0, cmp_oe: 1'b1};
        end
      end
    endcase
  end

  // pin register; reset looks like power down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_r <= '{clk: 1'b0, clk_oe: 1'b1, cmp: 1'b0, cmp_oe: 1'b1};
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign pins_o = pins_r;
  assign drv_o  = drv;
  assign mode_o = mode;

  a_pdn_ground: assert property (@(posedge clk_i) disable iff (rst_i)
    !power_down_n_i |=> !pins_r.clk && !pins_r.cmp && pins_r.clk_oe && pins_r.cmp_oe)
    else $error("outputs not grounded in power down");
  a_stop_park: assert property (@(posedge clk_i) disable iff (rst_i)
    (power_down_n_i && !output_stop_n_i) |=> pins_r.clk == STOP_LEVEL && pins_r.cmp == STOP_LEVEL)
    else $error("outputs not parked during stop");
  a_hiz_modes: assert property (@(posedge clk_i) disable iff (rst_i)
    (power_down_n_i && output_stop_n_i && mode_select_1_i && !mode_select_0_i) |=> !pins_r.clk_oe && !pins_r.cmp_oe)
    else $error("outputs driven in float mode");
  a_test_source: assert property (@(posedge clk_i) disable iff (rst_i)
    (drv == DRV_RUN && mode == MODE_TEST) |=> pins_r.clk == $past(ref_i) && pins_r.cmp == !$past(ref_i))
    else $error("test mode did not pass the reference");
endmodule // cmoc_out_drv
`default_nettype wire

// ### design/cmoc_top.sv
// clock multiplier output control: ratio, lock tracking, aligner, drivers, register slave
// Operation
// - ratio selects multiply by 4, 6, 8, 16/3
// - output undefined until reference present and locked
// - power down grounds outputs; stop parks them
// - normal state picks aligned, pll or reference
// - mode pins encode aligned, bypass, test, float
// - aligner shifts phase to minimise divided skew
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module cmoc_top
  import cmoc_pkg::*;
#(
  parameter int unsigned TAPS = 8  // aligner delay line length
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ratio_select_0_i,
  input  wire logic        ratio_select_1_i,
  input  wire logic        power_down_n_i,
  input  wire logic        output_stop_n_i,
  input  wire logic        mode_select_0_i,
  input  wire logic        mode_select_1_i,
  input  wire logic        mode_select_2_i,
  input  wire logic        reference_clock_in_i,
  input  wire logic        pll_multiplied_clock_i,
  input  wire logic        processor_phase_input_i,
  input  wire logic        channel_phase_input_i,
  output logic             channel_clock_out_o,
  output logic             channel_clock_out_oe_o,
  output logic             output_complement_o,
  output logic             output_complement_oe_o,
  output logic [7:0]       pll_ratio_x3_o,
  output logic             pll_locked_o,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);
  // aligner tap must fit its status field
  if (TAPS < 2 || TAPS > 256) begin : g_bad_taps
    $error("TAPS must lie in 2..256");
  end

  localparam logic [7:0] REF_LOSS_MAX = 8'(REF_LOSS_CYC);

  // ratio select state
  logic [1:0] ratio_r, ratio_nxt;         // held {select1, select0}
  logic [7:0] ratio_x3_r, ratio_x3_nxt;   // multiply ratio in thirds
  logic       ratio_chg;                  // new ratio sampled this cycle

  // reference presence
  logic       ref_d_r, ref_d_nxt;         // previous reference sample
  logic [7:0] ref_gap_r, ref_gap_nxt;     // cycles since last reference edge
  logic       ref_valid_r, ref_valid_nxt; // reference toggling

  // lock acquisition
  cmoc_lk_e    lk_state_r, lk_state_nxt;
  logic [15:0] lk_cnt_r, lk_cnt_nxt;      // settle cycles spent
  logic        restart;                   // abandon current acquisition
  logic        locked;

  // register slave state
  logic [15:0] lock_wait_r, lock_wait_nxt; // settle time in cycles
  logic        dp_wr_r, dp_wr_nxt;         // write data phase pending
  logic [7:0]  dp_addr_r, dp_addr_nxt;     // address of that write
  logic [31:0] rdata_r, rdata_nxt;         // read data for the data phase
  logic        cfg_wr;                     // lock wait written
  logic        ap_take;                    // address phase accepted

  // aligner and driver wiring
  logic        aligned;
  logic [7:0]  tap;
  cmoc_pins_s  pins;
  cmoc_drv_e   drv;
  cmoc_mode_e  mode;
  logic [31:0] status;

  // ratio sampling; held while powered down so a floating select cannot bounce the pll
  always_comb begin
    ratio_chg    = 1'b0;
    ratio_nxt    = ratio_r;
    ratio_x3_nxt = ratio_x3_r;
    if (power_down_n_i) begin
      ratio_nxt = {ratio_select_1_i, ratio_select_0_i};
      ratio_chg = (ratio_nxt != ratio_r);
    end
    case (ratio_nxt)
      2'b00:   ratio_x3_nxt = RATIO_X3_4;
      2'b10:   ratio_x3_nxt = RATIO_X3_6;
      2'b11:   ratio_x3_nxt = RATIO_X3_8;
      2'b01:   ratio_x3_nxt = RATIO_X3_16_3;
      default: ratio_x3_nxt = RATIO_X3_4;
    endcase
  end

  // ratio registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio_r    <= 2'h0;
      ratio_x3_r <= RATIO_X3_4;
    end else begin
      ratio_r    <= ratio_nxt;
      ratio_x3_r <= ratio_x3_nxt;
    end
  end

  // reference watchdog: any edge within the loss window counts as present
  always_comb begin
    ref_d_nxt = reference_clock_in_i;
    if (reference_clock_in_i != ref_d_r) begin
      ref_gap_nxt = 8'h00;
    end else if (ref_gap_r != REF_LOSS_MAX) begin
      ref_gap_nxt = ref_gap_r + 8'h01;
    end else begin
      ref_gap_nxt = ref_gap_r;  // saturate
    end
    ref_valid_nxt = (ref_gap_nxt != REF_LOSS_MAX);
  end

  // reference registers; absent until edges are seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_d_r     <= 1'b0;
      ref_gap_r   <= REF_LOSS_MAX;
      ref_valid_r <= 1'b0;
    end else begin
      ref_d_r     <= ref_d_nxt;
      ref_gap_r   <= ref_gap_nxt;
      ref_valid_r <= ref_valid_nxt;
    end
  end

  // lock state machine: settle for lock_wait cycles with a steady reference
  always_comb begin
    restart      = !power_down_n_i || !ref_valid_r || ratio_chg || cfg_wr;
    lk_state_nxt = lk_state_r;
    lk_cnt_nxt   = lk_cnt_r;
    if (restart) begin
      lk_cnt_nxt   = 16'h0000;
      lk_state_nxt = (power_down_n_i && ref_valid_r) ? LK_ACQ : LK_IDLE;
    end else begin
      case (lk_state_r)
        LK_IDLE: begin
          lk_state_nxt = LK_ACQ;
        end
        LK_ACQ: begin
          lk_cnt_nxt = lk_cnt_r + 16'h0001;
          if (lk_cnt_nxt >= lock_wait_r) begin
            lk_state_nxt = LK_LOCKED;
          end
        end
        LK_LOCKED: begin
          lk_state_nxt = LK_LOCKED;
        end
        default: begin
          lk_state_nxt = LK_IDLE;
        end
      endcase
    end
  end

  // lock registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lk_state_r <= LK_IDLE;
      lk_cnt_r   <= 16'h0000;
    end else begin
      lk_state_r <= lk_state_nxt;
      lk_cnt_r   <= lk_cnt_nxt;
    end
  end

  assign locked = (lk_state_r == LK_LOCKED);

  // status word for software
  always_comb begin
    status                                   = 32'h0000_0000;
    status[STAT_REF_BIT]                     = ref_valid_r;
    status[STAT_LOCK_BIT]                    = locked;
    status[STAT_DRV_LSB +: 2]                = drv;
    status[STAT_MODE_LSB +: 2]               = mode;
    status[STAT_TAP_LSB +: 8]                = tap;
  end

  // ahb-lite slave, zero wait: read data is latched at the address phase
  always_comb begin
    ap_take       = hsel_i && htrans_i[1] && hready_i;
    dp_wr_nxt     = ap_take && hwrite_i;
    dp_addr_nxt   = ap_take ? haddr_i[7:0] : dp_addr_r;
    rdata_nxt     = 32'h0000_0000;  // unmapped reads as zero
    cfg_wr        = dp_wr_r && (dp_addr_r == ADDR_LOCK_WAIT);
    lock_wait_nxt = lock_wait_r;
    if (cfg_wr) begin
      // zero would lock at once; clamp to one cycle
      lock_wait_nxt = (hwdata_i[15:0] == 16'h0000) ? 16'h0001 : hwdata_i[15:0];
    end
    if (ap_take && !hwrite_i) begin
      case (haddr_i[7:0])
        ADDR_STATUS:    rdata_nxt = status;
        ADDR_LOCK_WAIT: rdata_nxt = {16'h0000, lock_wait_r};
        ADDR_RATIO:     rdata_nxt = {24'h00_0000, ratio_x3_r};
        default:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // slave registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_wait_r <= LOCK_WAIT_RST;
      dp_wr_r     <= 1'b0;
      dp_addr_r   <= 8'h00;
      rdata_r     <= 32'h0000_0000;
    end else begin
      lock_wait_r <= lock_wait_nxt;
      dp_wr_r     <= dp_wr_nxt;
      dp_addr_r   <= dp_addr_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign hrdata_o    = rdata_r;
  assign hreadyout_o = 1'b1;  // never stalls
  assign hresp_o     = 1'b0;  // always okay

  // phase aligner on the multiplied clock
  cmoc_phase_align #(
    .TAPS      (TAPS)
  ) u_align (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (locked),
    .pll_clk_i (pll_multiplied_clock_i),
    .proc_ph_i (processor_phase_input_i),
    .chan_ph_i (channel_phase_input_i),
    .aligned_o (aligned),
    .tap_o     (tap)
  );

  // pin pair driver
  cmoc_out_drv u_drv (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .power_down_n_i  (power_down_n_i),
    .output_stop_n_i (output_stop_n_i),
    .mode_select_0_i (mode_select_0_i),
    .mode_select_1_i (mode_select_1_i),
    .mode_select_2_i (mode_select_2_i),
    .locked_i        (locked),
    .aligned_i       (aligned),
    .pll_i           (pll_multiplied_clock_i),
    .ref_i           (reference_clock_in_i),
    .pins_o          (pins),
    .drv_o           (drv),
    .mode_o          (mode)
  );

  // outputs
  assign channel_clock_out_o    = pins.clk;
  assign channel_clock_out_oe_o = pins.clk_oe;
  assign output_complement_o    = pins.cmp;
  assign output_complement_oe_o = pins.cmp_oe;
  assign pll_ratio_x3_o         = ratio_x3_r;
  assign pll_locked_o           = locked;

  // checks
  sequence s_steady_ratio;
    power_down_n_i && $stable(ratio_select_0_i) && $stable(ratio_select_1_i);
  endsequence

  sequence s_ratio_change;
    power_down_n_i && ({ratio_select_1_i, ratio_select_0_i} != ratio_r);
  endsequence

  a_ratio_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    s_steady_ratio ##1 s_steady_ratio |-> ratio_x3_r ==
      (ratio_select_0_i ? (ratio_select_1_i ? 8'h18 : 8'h10) : (ratio_select_1_i ? 8'h12 : 8'h0c)))
    else $error("multiply ratio does not match select pins");

  a_ratio_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !power_down_n_i |=> ratio_r == $past(ratio_r))
    else $error("ratio resampled during power down");

  a_relock_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ratio_change |=> !locked ##1 !locked)
    else $error("lock kept across a ratio change");

  a_lock_needs_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(locked) |-> $past(ref_valid_r) && $past(lk_state_r) == LK_ACQ && $past(lk_cnt_r) + 16'h0001 >= lock_wait_r)
    else $error("lock declared without settling on a reference");

  a_lost_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    !ref_valid_r |=> !locked)
    else $error("lock held without reference");
endmodule // cmoc_top
`default_nettype wire

// ### sim/cmoc_far_model.sv
// far side model: reference source, pll clock stand-in and controller divided clocks
`timescale 1ns/1ns
`default_nettype none
module cmoc_far_model (
  input  wire logic ref_en_i,  // reference running
  output logic      ref_o,     // reference clock
  output logic      pll_o,     // multiplied clock stand-in
  output logic      proc_o,    // divided processor clock
  output logic      chan_o     // divided channel clock
);
  // reference scaled to the sampling clock; a stopped source sits low
  initial begin
    ref_o = 1'b0;
    #10;  // offset keeps reference edges clear of every clock edge
    forever #60 ref_o = ref_en_i ? ~ref_o : 1'b0;
  end
  // fast free-running clock, aliased on purpose so samples keep changing
  // edges on odd nanoseconds never meet a sampling edge
  initial begin
    pll_o = 1'b0;
    #1;
    forever #6 pll_o = ~pll_o;
  end
  // equal rates, offset far below half a period so the aligner can capture
  // channel leads, so the aligner must walk its delay upwards
  initial begin
    proc_o = 1'b0;
    chan_o = 1'b0;
    fork
      #80 forever #400 proc_o = ~proc_o;
      forever #400 chan_o = ~chan_o;
    join
  end
endmodule  // cmoc_far_model
`default_nettype wire

// ### sim/tb.sv
// self-checking bench of the clock multiplier output control
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cmoc_pkg::*;
  logic        clk_i;         // system clock
  logic        rst_i;         // sync reset
  logic        rs0, rs1;      // ratio pins
  logic        pdn_n, stp_n;  // power down, stop
  logic [2:0]  ms;            // mode pins 0 1 2, msb first
  logic        ref_en;        // reference running
  logic        hsel, hwrite;  // bus controls
  logic [1:0]  htrans;        // bus transfer kind
  logic [31:0] haddr, hwdata; // bus address, data
  logic [31:0] rd;            // last read word
  wire logic   ref_c, pll_c, proc_c, chan_c;
  wire logic   hrdy, hresp, co, co_oe, cc, cc_oe, lkd;
  wire logic [7:0]  rx3;
  wire logic [31:0] hrdata;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  localparam logic [7:0] RT [4] = '{8'h0c, 8'h12, 8'h10, 8'h18};  // index {rs0,rs1}
  localparam logic [1:0] MT [8] = '{2'h0, 2'h3, 2'h3, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3};  // index {sel0,sel1,sel2}

  cmoc_far_model far (.ref_en_i(ref_en), .ref_o(ref_c), .pll_o(pll_c), .proc_o(proc_c), .chan_o(chan_c));
  cmoc_top dut (.clk_i(clk_i), .rst_i(rst_i), .ratio_select_0_i(rs0), .ratio_select_1_i(rs1),
    .power_down_n_i(pdn_n), .output_stop_n_i(stp_n), .mode_select_0_i(ms[2]), .mode_select_1_i(ms[1]),
    .mode_select_2_i(ms[0]), .reference_clock_in_i(ref_c), .pll_multiplied_clock_i(pll_c),
    .processor_phase_input_i(proc_c), .channel_phase_input_i(chan_c), .channel_clock_out_o(co),
    .channel_clock_out_oe_o(co_oe), .output_complement_o(cc), .output_complement_oe_o(cc_oe),
    .pll_ratio_x3_o(rx3), .pll_locked_o(lkd), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp));

  // free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // one single transfer; entered just after a rising edge
  task automatic ahb(input int w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= (w != 0);
    @(posedge clk_i);
    while (hrdy !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_i);
    while (hrdy !== 1'b1) @(posedge clk_i);
    rd = hrdata;
    chk(hresp, 0, "error response");
  endtask
  task automatic set_pins(input int p, input int s, input logic [2:0] m);
    pdn_n <= (p != 0);
    stp_n <= (s != 0);
    ms <= m;
    repeat (3) @(posedge clk_i);
  endtask
  // bounded wait for lock; n returns the cycles taken
  task automatic wait_lock(output int n);
    n = 0;
    while (lkd !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk(lkd, 1, "no lock");
  endtask
  // pin pair over 16 cycles: floating, or complement and toggling
  task automatic watch(input logic [1:0] md);
    int tg;
    logic last;
    tg = 0;
    last = co;
    repeat (16) begin
      @(posedge clk_i);
      #1;
      if (md == 2'd3) chk({co_oe, cc_oe}, 2'b00, "not floating");
      else chk({co_oe, cc_oe, cc}, {2'b11, ~co}, "bad complement");
      tg += (co !== last);
      last = co;
    end
    if (md != 2'd3) chk(tg > 0, 1, "output stuck");
  endtask

  initial begin
    int n;
    rst_i = 1'b1;
    rs0 = 1'b0;
    rs1 = 1'b0;
    pdn_n = 1'b1;
    stp_n = 1'b1;
    ms = 3'b000;
    ref_en = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = '0;
    hwdata = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, unmapped place
    ahb(0, ADDR_LOCK_WAIT, 0);
    chk(rd, {16'h0, LOCK_WAIT_RST}, "lock wait reset");
    ahb(0, ADDR_RATIO, 0);
    chk(rd, 32'h0000_000c, "ratio reset");
    ahb(1, 8'h0c, 32'hffff_ffff);
    ahb(0, 8'h0c, 0);
    chk(rd, 0, "unmapped read");
    $display("test reset done");
    // short lock wait, lock needs at least that many cycles
    ahb(1, ADDR_LOCK_WAIT, 32'h4);
    chk(lkd, 0, "locked early");
    wait_lock(n);
    chk(n >= 4, 1, "lock too fast");
    ahb(0, ADDR_STATUS, 0);
    chk(rd[1:0], 2'b11, "status ref and lock");
    $display("test lock done");
    // every ratio code; any change restarts lock
    for (int i = 0; i < 4; i++) begin
      rs0 <= i[1];
      rs1 <= i[0];
      repeat (3) @(posedge clk_i);
      chk(rx3, RT[i], "ratio code");
    end
    chk(lkd, 0, "lock kept over ratio change");
    // power down grounds both pins with stop also asserted, ratio frozen
    set_pins(0, 0, 3'b000);
    rs0 <= 1'b0;
    rs1 <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(rx3, 8'h18, "ratio sampled in power down");
    chk({co, co_oe, cc, cc_oe}, 4'b0101, "power down pins");
    ahb(0, ADDR_STATUS, 0);
    chk(rd[3:2], 2'd0, "driver power down");
    set_pins(1, 0, 3'b000);
    chk({co, co_oe, cc, cc_oe}, {STOP_LEVEL, 1'b1, STOP_LEVEL, 1'b1}, "stop pins");
    chk(rx3, 8'h0c, "ratio after release");
    ahb(0, ADDR_STATUS, 0);
    chk(rd[3:2], 2'd1, "driver stop");
    wait_lock(n);
    $display("test power done");
    // every mode code in the normal state
    for (int m = 0; m < 8; m++) begin
      set_pins(1, 1, m[2:0]);
      watch(MT[m]);
      ahb(0, ADDR_STATUS, 0);
      chk(rd[5:2], {MT[m], 2'd2}, "mode and driver field");
    end
    // leading channel drives the default eight-tap line to its last tap
    chk(rd[15:8], 8'h07, "aligner short of full delay");
    $display("test modes done");
    // lost reference drops lock and presence
    ref_en <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(lkd, 0, "lock kept without reference");
    ahb(0, ADDR_STATUS, 0);
    chk(rd[1:0], 2'b00, "status after loss");
    $display("test reference loss done");
    print_verdict();
  end
endmodule  // tb
`default_nettype wire
